// *** crate_dataway_srq_control.sv ***
/*
  Crate bus controller: drives station, subaddress, function, write data and
  common controls, captures read data with X and Q, raises service requests.
  Assumes commands and poll events arrive synchronous to REF_CLK_I from the
  bus controller logic, and that read data is drained through the FIFO port.
*/
// How it works
// - X and Q captured every cycle and shown on the response outputs.
// - Captured X and Q feed service requests and end block transfers.
// - Attention lines feed requests and are readable during a serial poll.
// - Enabled sources: attention line, zero X, zero Q raise a request.
// - No bus cycle starts while a service request is pending.
// - Attention still set when polling ends raises a new request at once.
// - Up to 25 stations from 1; two rightmost belong to the controller.
// - Each normal station has its own dedicated select line.
// - Four subaddress lines select subsections 0 to 15.
// - Five function lines weighted 16,8,4,2,1 select functions 0 to 31.
// - Station, subaddress and function held steady for the whole cycle.
// - 24-bit data with separate write and read line groups.
// - Write data present from the start of every cycle.
// - Initialize, clear and inhibit reach all modules without addressing.
// - Serial poll disable clears a pending service request.
// - End of first strobe captures 24 read bits with X and Q.
`timescale 1ns/1ns

module rsp_fifo #(
  parameter int WIDTH = 26,
  parameter int DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o,
  output logic drained_o
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PW-1:0] wr_ptr_r;
  logic [PW-1:0] rd_ptr_r;
  logic [PW:0] cnt_r;
  logic push;
  logic pop;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("FIFO depth must be a power of two, at least 2");
  end

  assign in_ready_o = cnt_r != (PW + 1)'(DEPTH);
  assign push = in_valid_i && in_ready_o;
  assign pop = (cnt_r != '0) && (!out_valid_o || out_ready_i);
  assign drained_o = (cnt_r == '0) && !out_valid_o;

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r <= '0;
      out_valid_o <= 1'b0;
      out_data_o <= '0;
    end else begin
      wr_ptr_r <= wr_ptr_r + PW'(push);
      rd_ptr_r <= rd_ptr_r + PW'(pop);
      cnt_r <= cnt_r + (PW + 1)'(push) - (PW + 1)'(pop);
      if (pop) begin
        out_valid_o <= 1'b1;
        out_data_o <= mem_r[rd_ptr_r];
      end else if (out_ready_i) begin
        out_valid_o <= 1'b0;
      end
    end
  end
endmodule : rsp_fifo

module crate_dataway_srq_control #(
  parameter int NSTN = crate_dataway_pkg::NORMAL_STATIONS,
  parameter int FIFO_DEPTH = crate_dataway_pkg::FIFO_DEPTH_DEF
) (
  input wire logic REF_CLK_I,
  input wire logic RSTN_I,
  // Command side
  input wire logic CMD_VALID_I,
  output logic CMD_READY_O,
  input wire logic [crate_dataway_pkg::STN_W-1:0] CMD_N_I,
  input wire logic [crate_dataway_pkg::SUB_W-1:0] CMD_A_I,
  input wire logic [crate_dataway_pkg::FUNC_W-1:0] CMD_F_I,
  input wire logic [crate_dataway_pkg::DATA_W-1:0] CMD_W_I,
  input wire logic CMD_Z_I,
  input wire logic CMD_C_I,
  input wire logic CMD_I_I,
  input wire logic CMD_BLOCK_I,
  // Request source enables and poll events
  input wire logic CFG_WE_I,
  input wire logic CFG_LAM_EN_I,
  input wire logic CFG_X_EN_I,
  input wire logic CFG_Q_EN_I,
  input wire logic IFC_I,
  input wire logic SPE_I,
  input wire logic SPD_I,
  output logic SRQ_O,
  output logic POLL_ACTIVE_O,
  output logic [NSTN-1:0] POLL_LAM_O,
  output logic RSP_X_O,
  output logic RSP_Q_O,
  // Read data stream
  output logic RD_VALID_O,
  input wire logic RD_READY_I,
  output logic [crate_dataway_pkg::DATA_W-1:0] RD_DATA_O,
  output logic RD_X_O,
  output logic RD_Q_O,
  // Crate bus
  output logic B_O,
  output logic S1_O,
  output logic S2_O,
  output logic [NSTN-1:0] N_O,
  output logic [crate_dataway_pkg::SUB_W-1:0] A_O,
  output logic [crate_dataway_pkg::FUNC_W-1:0] F_O,
  output logic [crate_dataway_pkg::DATA_W-1:0] W_O,
  output logic Z_O,
  output logic C_O,
  output logic I_O,
  input wire logic [crate_dataway_pkg::DATA_W-1:0] R_I,
  input wire logic X_I,
  input wire logic Q_I,
  input wire logic [NSTN-1:0] L_I
);
  import crate_dataway_pkg::*;

  if (NSTN < 1 || NSTN > NORMAL_STATIONS) begin : g_bad_nstn
    $error("Normal station count must be 1 to 23");
  end

  seq_state_type state_r, state_nxt;
  logic [2:0] cnt_r, cnt_nxt;
  logic [STN_W-1:0] stn_r, stn_nxt;
  logic [SUB_W-1:0] sub_r, sub_nxt;
  logic [FUNC_W-1:0] func_r, func_nxt;
  logic [DATA_W-1:0] wdata_r, wdata_nxt;
  logic [DATA_W-1:0] rdata_r;
  logic z_r, z_nxt, c_r, c_nxt, inh_r, inh_nxt;
  logic block_r, block_nxt;
  logic lam_en_r, x_en_r, q_en_r;
  logic srq_r, srq_nxt;
  logic poll_r, poll_nxt;
  logic [NSTN-1:0] n_dec;
  logic cmd_take, special, start, capture, cyc_end, drive;
  logic lam_set, x_set, q_set, blk_stop;
  logic fifo_ready, fifo_drained;
  logic [RSP_W-1:0] fifo_din, fifo_dout;

  // Command acceptance and readout command
  assign cmd_take = CMD_VALID_I && CMD_READY_O;
  assign special = (CMD_N_I == READOUT_STATION) && (CMD_A_I == READOUT_SUB) && (CMD_F_I == READOUT_FUNC);
  assign start = (state_r == ST_IDLE) && !srq_r && !IFC_I &&
                 ((cmd_take && !special) || (block_r && fifo_drained));
  assign capture = (state_r == ST_S1) && (cnt_r == '0);
  assign cyc_end = (state_r == ST_TAIL) && (cnt_r == '0);

  // Latched command fields; Z and C clear at cycle end, block at zero X or Q, others held until overwritten
  assign stn_nxt = cmd_take ? CMD_N_I : stn_r;
  assign sub_nxt = cmd_take ? CMD_A_I : sub_r;
  assign func_nxt = cmd_take ? CMD_F_I : func_r;
  assign wdata_nxt = cmd_take ? CMD_W_I : wdata_r;
  assign z_nxt = cmd_take ? CMD_Z_I : (z_r && !cyc_end);
  assign c_nxt = cmd_take ? CMD_C_I : (c_r && !cyc_end);
  assign inh_nxt = cmd_take ? CMD_I_I : inh_r;
  assign blk_stop = capture && (!X_I || !Q_I);
  assign block_nxt = cmd_take ? (CMD_BLOCK_I && !special) : (block_r && !blk_stop);

  // Individual station select lines, stations 1..NSTN
  for (genvar k = 0; k < NSTN; k++) begin : g_ndec
    assign n_dec[k] = stn_nxt == STN_W'(k + 1);
  end

  // Request sources
  assign lam_set = lam_en_r && (|L_I) && !poll_r;
  assign x_set = capture && x_en_r && !X_I;
  assign q_set = capture && q_en_r && !Q_I;
  assign srq_nxt = lam_set || x_set || q_set || (srq_r && !SPD_I);
  assign poll_nxt = SPE_I || (poll_r && !SPD_I);

  // Cycle sequencer
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r - 3'h1;
    case (state_r)
      ST_IDLE: begin
        cnt_nxt = SETUP_LAST;
        if (start) begin
          state_nxt = ST_SETUP;
        end
      end
      ST_SETUP: begin
        if (cnt_r == '0) begin
          state_nxt = ST_S1;
          cnt_nxt = S1_LAST;
        end
      end
      ST_S1: begin
        if (cnt_r == '0) begin
          state_nxt = ST_GAP;
          cnt_nxt = GAP_LAST;
        end
      end
      ST_GAP: begin
        if (cnt_r == '0) begin
          state_nxt = ST_S2;
          cnt_nxt = S2_LAST;
        end
      end
      ST_S2: begin
        if (cnt_r == '0) begin
          state_nxt = ST_TAIL;
          cnt_nxt = TAIL_LAST;
        end
      end
      ST_TAIL: begin
        if (cnt_r == '0) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
        cnt_nxt = '0;
      end
    endcase
    if (IFC_I) begin
      state_nxt = ST_IDLE;
      cnt_nxt = '0;
    end
  end

  assign drive = state_nxt != ST_IDLE;

  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      state_r <= ST_IDLE;
      cnt_r <= '0;
      B_O <= 1'b0;
      S1_O <= 1'b0;
      S2_O <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      B_O <= drive;
      S1_O <= state_nxt == ST_S1;
      S2_O <= state_nxt == ST_S2;
    end
  end

  // Bus drivers, enabled only while busy
  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      N_O <= '0;
      A_O <= '0;
      F_O <= '0;
      W_O <= '0;
      Z_O <= 1'b0;
      C_O <= 1'b0;
      I_O <= 1'b0;
    end else begin
      N_O <= drive ? n_dec : '0;
      A_O <= drive ? sub_nxt : '0;
      F_O <= drive ? func_nxt : '0;
      W_O <= drive ? wdata_nxt : '0;
      Z_O <= drive && z_nxt;
      C_O <= drive && c_nxt;
      I_O <= drive && inh_nxt;
    end
  end

  // Command latches, enables, request and poll state
  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      stn_r <= '0;
      sub_r <= '0;
      func_r <= '0;
      wdata_r <= '0;
      z_r <= 1'b0;
      c_r <= 1'b0;
      inh_r <= 1'b0;
      block_r <= 1'b0;
      lam_en_r <= EN_RST;
      x_en_r <= EN_RST;
      q_en_r <= EN_RST;
      srq_r <= SRQ_RST;
      poll_r <= 1'b0;
      CMD_READY_O <= 1'b0;
    end else if (IFC_I) begin
      stn_r <= '0;
      sub_r <= '0;
      func_r <= '0;
      wdata_r <= '0;
      z_r <= 1'b0;
      c_r <= 1'b0;
      inh_r <= 1'b0;
      block_r <= 1'b0;
      lam_en_r <= EN_RST;
      x_en_r <= EN_RST;
      q_en_r <= EN_RST;
      srq_r <= SRQ_RST;
      poll_r <= 1'b0;
      CMD_READY_O <= 1'b0;
    end else begin
      stn_r <= stn_nxt;
      sub_r <= sub_nxt;
      func_r <= func_nxt;
      wdata_r <= wdata_nxt;
      z_r <= z_nxt;
      c_r <= c_nxt;
      inh_r <= inh_nxt;
      block_r <= block_nxt;
      if (CFG_WE_I) begin
        lam_en_r <= CFG_LAM_EN_I;
        x_en_r <= CFG_X_EN_I;
        q_en_r <= CFG_Q_EN_I;
      end
      srq_r <= srq_nxt;
      poll_r <= poll_nxt;
      CMD_READY_O <= !drive && !cmd_take && !block_nxt && !srq_nxt && fifo_ready;
    end
  end

  // Response capture and status outputs
  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      rdata_r <= '0;
      RSP_X_O <= 1'b0;
      RSP_Q_O <= 1'b0;
      SRQ_O <= SRQ_RST;
      POLL_ACTIVE_O <= 1'b0;
      POLL_LAM_O <= '0;
    end else begin
      if (capture) begin
        rdata_r <= R_I;
        RSP_X_O <= X_I;
        RSP_Q_O <= Q_I;
      end
      SRQ_O <= IFC_I ? SRQ_RST : srq_nxt;
      POLL_ACTIVE_O <= !IFC_I && poll_nxt;
      POLL_LAM_O <= poll_r ? L_I : '0;
    end
  end

  // Read data path; readout command repeats the last capture
  assign fifo_din = capture ? {X_I, Q_I, R_I} : {RSP_X_O, RSP_Q_O, rdata_r};

  rsp_fifo #(
    .WIDTH(RSP_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(REF_CLK_I),
    .rstn_i(RSTN_I),
    .in_valid_i(capture || (cmd_take && special)),
    .in_ready_o(fifo_ready),
    .in_data_i(fifo_din),
    .out_valid_o(RD_VALID_O),
    .out_ready_i(RD_READY_I),
    .out_data_o(fifo_dout),
    .drained_o(fifo_drained)
  );

  assign RD_X_O = fifo_dout[RSP_W-1];
  assign RD_Q_O = fifo_dout[RSP_W-2];
  assign RD_DATA_O = fifo_dout[DATA_W-1:0];

  // Checks
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!RSTN_I);

  property p_no_start_on_srq;
    $rose(B_O) |-> !$past(SRQ_O);
  endproperty
  a_no_start_on_srq: assert property (p_no_start_on_srq) else $error("Cycle started with request pending");

  property p_hold_fields;
    B_O && $past(B_O) |-> $stable(N_O) && $stable(A_O) && $stable(F_O) && $stable(W_O);
  endproperty
  a_hold_fields: assert property (p_hold_fields) else $error("Command lines changed during cycle");

  property p_capture;
    $fell(S1_O) |-> RSP_X_O == $past(X_I) && RSP_Q_O == $past(Q_I) && rdata_r == $past(R_I);
  endproperty
  a_capture: assert property (p_capture) else $error("Response not captured at strobe end");

  property p_x_srq;
    $fell(S1_O) && !$past(X_I) && $past(x_en_r) && !$past(IFC_I) |-> SRQ_O;
  endproperty
  a_x_srq: assert property (p_x_srq) else $error("Zero X did not raise request");

  property p_block_end;
    $fell(S1_O) && (!$past(X_I) || !$past(Q_I)) |-> !block_r;
  endproperty
  a_block_end: assert property (p_block_end) else $error("Block mode not ended");

  property p_spd_clear;
    SPD_I && poll_r && !capture && !IFC_I |=> !SRQ_O;
  endproperty
  a_spd_clear: assert property (p_spd_clear) else $error("Poll disable did not clear request");

  property p_lam_again;
    SPD_I && poll_r ##1 (lam_en_r && (|L_I) && !SPE_I && !IFC_I) |=> SRQ_O;
  endproperty
  a_lam_again: assert property (p_lam_again) else $error("Attention did not re-raise request");

  property p_ifc_enables;
    IFC_I |=> !lam_en_r && !x_en_r && !q_en_r && !SRQ_O;
  endproperty
  a_ifc_enables: assert property (p_ifc_enables) else $error("Interface clear left enables set");

  property p_onehot_station;
    $onehot0(N_O) && (B_O || N_O == '0);
  endproperty
  a_onehot_station: assert property (p_onehot_station) else $error("Station lines not one-hot");

  property p_poll_lam;
    poll_r |=> POLL_LAM_O == $past(L_I);
  endproperty
  a_poll_lam: assert property (p_poll_lam) else $error("Attention lines not readable in poll");

  c_block: cover property (block_r && $fell(B_O) ##[1:200] $rose(B_O));
  c_lam_srq: cover property (!SRQ_O && lam_en_r ##1 SRQ_O);
  c_readout: cover property (cmd_take && special);
  c_fifo_full: cover property (!fifo_ready);
endmodule : crate_dataway_srq_control

// *** crate_dataway_pkg.sv ***
/*
  Constants and types for the crate bus controller with service requests.
  Assumes a single 10 MHz reference clock; all times are rounded to cycles here.
*/
package crate_dataway_pkg;

  // Clock
  localparam int CLK_PERIOD_NS = 100;

  // Crate layout
  localparam int CRATE_STATIONS = 25;
  localparam int NORMAL_STATIONS = CRATE_STATIONS - 2;
  localparam logic [4:0] READOUT_STATION = 5'h18;
  localparam logic [3:0] READOUT_SUB = 4'h0;
  localparam logic [4:0] READOUT_FUNC = 5'h00;

  // Field widths
  localparam int STN_W = 5;
  localparam int SUB_W = 4;
  localparam int FUNC_W = 5;
  localparam int DATA_W = 24;
  localparam int RSP_W = DATA_W + 2;
  localparam int FIFO_DEPTH_DEF = 16;

  // Cycle timing, least times rounded up
  localparam int T_SETUP_NS = 500;
  localparam int T_S1_NS = 250;
  localparam int T_GAP_NS = 125;
  localparam int T_S2_NS = 250;
  localparam int T_TAIL_NS = 125;
  localparam int SETUP_CYC = (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int S1_CYC = (T_S1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GAP_CYC = (T_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int S2_CYC = (T_S2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TAIL_CYC = (T_TAIL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0] SETUP_LAST = 3'(SETUP_CYC - 1);
  localparam logic [2:0] S1_LAST = 3'(S1_CYC - 1);
  localparam logic [2:0] GAP_LAST = 3'(GAP_CYC - 1);
  localparam logic [2:0] S2_LAST = 3'(S2_CYC - 1);
  localparam logic [2:0] TAIL_LAST = 3'(TAIL_CYC - 1);

  // Reset values
  localparam logic SRQ_RST = 1'b0;
  localparam logic EN_RST = 1'b0;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SETUP = 3'b001,
    ST_S1 = 3'b010,
    ST_GAP = 3'b011,
    ST_S2 = 3'b100,
    ST_TAIL = 3'b101
  } seq_state_type;

endpackage : crate_dataway_pkg

// *** dataway_modules.sv ***
/*
  Behavioural crate modules: per-station storage, X, Q and attention lines.
  Assumes one-hot station lines and busy framing from the controller.
*/
`timescale 1ns/1ns
module dataway_modules #(
  parameter int NSTN = 23,
  parameter logic [4:0] CLR_LAM_F = 5'h0A
) (
  input wire logic clk_i,
  input wire logic b_i,
  input wire logic [NSTN-1:0] n_i,
  input wire logic [4:0] f_i,
  input wire logic [23:0] w_i,
  input wire logic z_i,
  input wire logic c_i,
  input wire logic i_i,
  input wire logic x_ok_i,
  input wire logic q_ok_i,
  input wire logic [NSTN-1:0] lam_req_i,
  output logic [23:0] r_o,
  output logic x_o,
  output logic q_o,
  output logic [NSTN-1:0] l_o
);
  logic [23:0] store_r [NSTN];
  logic [23:0] rd;
  logic sel;
  assign sel = |n_i;
  always_comb begin
    rd = '0;
    for (int k = 0; k < NSTN; k++) begin
      if (n_i[k]) rd = rd | store_r[k];
    end
  end
  // Released lines idle low
  assign r_o = (b_i && f_i < 5'h08) ? rd : '0;
  assign x_o = b_i & sel & x_ok_i;
  assign q_o = b_i & sel & q_ok_i;
  initial begin
    l_o = '0;
    for (int k = 0; k < NSTN; k++) store_r[k] = '0;
  end
  always @(posedge clk_i) begin
    for (int k = 0; k < NSTN; k++) begin
      if (z_i || c_i) store_r[k] <= '0;
      else if (b_i && n_i[k] && f_i[4:3] == 2'b10) store_r[k] <= w_i;
      if (z_i || !lam_req_i[k] || (b_i && n_i[k] && f_i == CLR_LAM_F)) l_o[k] <= 1'b0;
      else if (!b_i && !i_i) l_o[k] <= 1'b1;
    end
  end
endmodule : dataway_modules

// *** tb.sv ***
/*
  Self-checking bench for the crate bus controller with a queue model.
  Assumes dataway_modules stands in for the crate modules.
*/
`timescale 1ns/1ns
module tb;
  localparam int DEPTH = 16;
  logic clk, rstn, cmd_valid, cmd_z, cmd_c, cmd_i, cmd_block, cfg_we, lam_en, x_en, q_en;
  logic ifc, spe, spd, rd_ready, x_ok, q_ok, hold, tk;
  logic ready, srq, poll, rsp_x, rsp_q, rd_valid, rd_x, rd_q, b, s1, s2, z, c, i_o, x, q;
  logic [4:0] cmd_n, cmd_f, f;
  logic [3:0] cmd_a, a;
  logic [23:0] cmd_w, w, r, rd_data;
  logic [22:0] n, l, lam_req, poll_lam;
  logic [25:0] exp_q[$];
  logic [25:0] last_word;
  int store[23];
  int bad_count, checks, cyc, bc, rd_count, t, base, taken;

  crate_dataway_srq_control #(.NSTN(23), .FIFO_DEPTH(DEPTH)) u_dut (
    .REF_CLK_I(clk), .RSTN_I(rstn), .CMD_VALID_I(cmd_valid), .CMD_READY_O(ready),
    .CMD_N_I(cmd_n), .CMD_A_I(cmd_a), .CMD_F_I(cmd_f), .CMD_W_I(cmd_w), .CMD_Z_I(cmd_z),
    .CMD_C_I(cmd_c), .CMD_I_I(cmd_i), .CMD_BLOCK_I(cmd_block), .CFG_WE_I(cfg_we),
    .CFG_LAM_EN_I(lam_en), .CFG_X_EN_I(x_en), .CFG_Q_EN_I(q_en), .IFC_I(ifc), .SPE_I(spe),
    .SPD_I(spd), .SRQ_O(srq), .POLL_ACTIVE_O(poll), .POLL_LAM_O(poll_lam), .RSP_X_O(rsp_x),
    .RSP_Q_O(rsp_q), .RD_VALID_O(rd_valid), .RD_READY_I(rd_ready), .RD_DATA_O(rd_data),
    .RD_X_O(rd_x), .RD_Q_O(rd_q), .B_O(b), .S1_O(s1), .S2_O(s2), .N_O(n), .A_O(a), .F_O(f),
    .W_O(w), .Z_O(z), .C_O(c), .I_O(i_o), .R_I(r), .X_I(x), .Q_I(q), .L_I(l));

  dataway_modules #(.NSTN(23)) u_mods (.clk_i(clk), .b_i(b), .n_i(n), .f_i(f), .w_i(w),
    .z_i(z), .c_i(c), .i_i(i_o), .x_ok_i(x_ok), .q_ok_i(q_ok), .lam_req_i(lam_req),
    .r_o(r), .x_o(x), .q_o(q), .l_o(l));

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic conclude;
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : conclude

  task automatic wait_idle;
    for (int k = 0; k < 40 && b !== 1'b0; k++) @(negedge clk);
    repeat (3) @(negedge clk);
  endtask : wait_idle

  task automatic cmd(input int stn, ff, aa, input logic [23:0] ww, input logic zz, cc, ii, blk);
    logic [25:0] e;
    int k;
    e = (stn == 24) ? last_word : {x_ok, q_ok, (ff < 8) ? 24'(store[stn-1]) : 24'h0};
    @(negedge clk);
    {cmd_n, cmd_f, cmd_a, cmd_w} = {5'(stn), 5'(ff), 4'(aa), ww};
    {cmd_z, cmd_c, cmd_i, cmd_block, cmd_valid} = {zz, cc, ii, blk, 1'b1};
    for (k = 0; k < 40 && ready !== 1'b1; k++) @(negedge clk);
    tk = (k < 40);
    @(negedge clk);
    cmd_valid = 0;
    if (!tk) return;
    if (stn == 24) chk(b, 0);
    else last_word = e;
    if (!blk) exp_q.push_back(e);
    for (k = 0; k < 23; k++) if (zz || cc) store[k] = 0;
    if (!(zz || cc) && ff >= 16 && ff < 24) store[stn-1] = ww;
    if (!blk) wait_idle();
    if (!blk && stn != 24) chk({rsp_x, rsp_q}, e[25:24]);
  endtask : cmd

  task automatic cfg(input logic le, xe, qe);
    @(negedge clk);
    {lam_en, x_en, q_en, cfg_we} = {le, xe, qe, 1'b1};
    @(negedge clk);
    cfg_we = 0;
  endtask : cfg

  task automatic refuse;
    logic seen;
    seen = 0;
    @(negedge clk);
    cmd_valid = 1;
    repeat (20) begin
      @(negedge clk);
      seen = seen | b | ready;
    end
    cmd_valid = 0;
    chk({seen, srq}, 2'b01);
  endtask : refuse

  task automatic poll_seq(input logic [22:0] el);
    @(negedge clk);
    spe = 1;
    @(negedge clk);
    spe = 0;
    repeat (2) @(negedge clk);
    chk({poll, poll_lam}, {1'b1, el});
    spd = 1;
    @(negedge clk);
    spd = 0;
    @(negedge clk);
  endtask : poll_seq

  initial begin
    clk = 0;
    forever #50 clk = ~clk;
  end

  always @(negedge clk) rd_ready <= !hold && ($urandom % 4 != 0);

  // Bus framing, stability and read stream
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      conclude();
    end
    if (b) begin
      chk({n, a, f}, {23'(1) << (cmd_n - 5'h01), cmd_a, cmd_f});
      chk({w, z, c}, {cmd_w, cmd_z, cmd_c});
      chk({s1, s2}, {bc >= 5 && bc <= 7, bc >= 10 && bc <= 12});
      if (cmd_i) chk(i_o, 1);
    end else begin
      chk({n, a, f, w, z, c}, 0);
      if (bc != 0) chk(bc, 15);
    end
    bc = b ? bc + 1 : 0;
    if (rd_valid === 1'b1 && rd_ready) begin
      rd_count++;
      if (exp_q.size() == 0) chk(rd_count, 0);
      else chk({rd_x, rd_q, rd_data}, exp_q.pop_front());
    end
  end

  initial begin
    {rstn, cmd_valid, cmd_z, cmd_c, cmd_i, cmd_block, cfg_we, lam_en, x_en, q_en} = '0;
    {ifc, spe, spd, hold, rd_ready, x_ok, q_ok} = 7'h03;
    {cmd_n, cmd_f, cmd_a, cmd_w, lam_req} = '0;
    void'($urandom(32'h27B2));
    repeat (20) @(negedge clk);
    chk({ready, srq, b, rd_valid}, 0);
    rstn = 1;
    for (int p = 0; p < 64; p++) begin
      x_ok = 1'($urandom);
      q_ok = 1'($urandom);
      cmd((p & 1) ? 23 : 1, p % 32, p % 16, 24'($urandom), p == 52, p == 57, p == 60, 1'b0);
    end
    cmd(24, 0, 0, 24'h0, 0, 0, 0, 0);
    {x_ok, q_ok} = 2'b11;
    cmd(3, 16, 0, 24'hA5C3E1, 0, 0, 0, 0);
    base = rd_count;
    cmd(3, 0, 0, 24'h0, 0, 0, 0, 1'b1);
    repeat (3) exp_q.push_back({2'b11, 24'hA5C3E1});
    exp_q.push_back({2'b10, 24'hA5C3E1});
    for (t = 0; t < 400 && rd_count < base + 3; t++) @(negedge clk);
    q_ok = 0;
    repeat (60) @(negedge clk);
    chk(rd_count - base, 4);
    q_ok = 1;
    hold = 1;
    taken = 0;
    do begin
      cmd($urandom_range(1, 23), $urandom_range(0, 31), $urandom_range(0, 15), 24'($urandom), 0, 0, 0, 0);
      taken += tk;
    end while (tk && taken < 30);
    chk(taken, DEPTH + 1);
    hold = 0;
    for (int s = 0; s < 2; s++) begin
      cfg(1'b0, s == 0, s == 1);
      {x_ok, q_ok} = {1'(s), 1'(!s)};
      cmd(4, 0, 0, 24'h0, 0, 0, 0, 0);
      chk(srq, 1);
      refuse();
      poll_seq(23'h0);
      chk(srq, 0);
    end
    cfg(1'b1, 1'b0, 1'b0);
    lam_req = 23'h000040;
    repeat (4) @(negedge clk);
    chk(srq, 1);
    poll_seq(23'h000040);
    repeat (3) @(negedge clk);
    chk(srq, 1);
    ifc = 1;
    @(negedge clk);
    ifc = 0;
    repeat (5) @(negedge clk);
    chk(srq, 0);
    lam_req = 0;
    {x_ok, q_ok} = 2'b00;
    cmd(2, 0, 0, 24'h0, 0, 0, 0, 0);
    chk(srq, 0);
    for (t = 0; t < 300 && exp_q.size() != 0; t++) @(negedge clk);
    chk(exp_q.size(), 0);
    conclude();
  end
endmodule : tb
